/* File: rtl/amd_decoder.sv */
`timescale 1ns/1ps
module amd_decoder (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  instr_valid,
  output logic                       instr_ready,
  input  wire amd_pkg::amd_mode_t    instr_mode,
  input  wire amd_pkg::amd_mask_op_t instr_mask_op,
  input  wire logic                  instr_rmw,
  input  wire logic                  instr_use_y,
  input  wire logic [15:0]           instr_pc,
  input  wire logic [7:0]            idx_x,
  input  wire logic [7:0]            idx_y,
  output logic                       mem_req,
  output logic [15:0]                mem_addr,
  input  wire logic [7:0]            mem_rdata,
  input  wire logic                  mem_ack,
  output logic                       ea_valid,
  output logic [15:0]                ea_addr,
  output logic [7:0]                 imm_data,
  output logic [7:0]                 rel_offset,
  output logic [15:0]                next_pc,
  output logic [1:0]                 opnd_bytes,
  output logic                       mode_error,
  output logic [1:0]                 int_mask
);
  import amd_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_OPND = 4'h2,
    ST_PTR  = 4'h4,
    ST_DONE = 4'h8
  } amd_state_t;

  amd_state_t  st_q;
  amd_state_t  st_d;
  amd_mode_t   mode_q;
  logic [15:0] pc_q;
  logic [15:0] addr_q;
  logic [15:0] word_q;
  logic [15:0] ptr_q;
  logic [7:0]  idx_q;
  logic [1:0]  ileft_q;
  logic [1:0]  pleft_q;
  logic [1:0]  nbytes_q;
  logic        take;
  logic        bad;
  logic        opnd_ack;
  logic        ptr_ack;
  logic        opnd_last;
  logic        ptr_last;
  logic [7:0]  ptr_base;
  logic        valid_q;
  logic [15:0] ea_q;
  logic [7:0]  imm_q;
  logic [7:0]  rel_q;
  logic [15:0] npc_q;
  logic [1:0]  obytes_q;
  logic        err_q;
  logic [1:0]  mask_q;

  amd_ea_if eif ();

  assign instr_ready = (st_q == ST_IDLE);
  assign take        = instr_valid && instr_ready;
  assign bad         = instr_rmw && is_long(instr_mode);
  assign opnd_ack    = (st_q == ST_OPND) && mem_ack;
  assign ptr_ack     = (st_q == ST_PTR) && mem_ack;
  assign opnd_last   = opnd_ack && (ileft_q == AMD_CNT_ONE);
  assign ptr_last    = ptr_ack && (pleft_q == AMD_CNT_ONE);

  // The pointer address is always the first operand byte.
  assign ptr_base = (nbytes_q == AMD_CNT_ONE) ? mem_rdata : word_q[7:0];

  assign mem_req  = (st_q == ST_OPND) || (st_q == ST_PTR);
  assign mem_addr = addr_q;

  assign eif.mode = mode_q;
  assign eif.idx  = idx_q;
  assign eif.word = word_q;
  assign eif.ptr  = ptr_q;
  assign eif.pc   = pc_q;

  amd_ea_calc u_calc (
    .ea (eif.calc)
  );

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (take && !bad) begin
          if (instr_bytes(instr_mode) != AMD_CNT_ZERO) begin
            st_d = ST_OPND;
          end else begin
            st_d = ST_DONE;
          end
        end
      end
      ST_OPND: begin
        if (opnd_last) begin
          if (ptr_bytes(mode_q) != AMD_CNT_ZERO) begin
            st_d = ST_PTR;
          end else begin
            st_d = ST_DONE;
          end
        end
      end
      ST_PTR: begin
        if (ptr_last) begin
          st_d = ST_DONE;
        end
      end
      ST_DONE: begin
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Request context captured when an instruction is accepted.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_q   <= AMD_INH;
      idx_q    <= '0;
      nbytes_q <= AMD_CNT_ZERO;
    end else if (take && !bad) begin
      mode_q   <= instr_mode;
      idx_q    <= instr_use_y ? idx_y : idx_x;
      nbytes_q <= instr_bytes(instr_mode);
    end
  end

  // Byte counters for the instruction stream and the pointer read.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ileft_q <= AMD_CNT_ZERO;
      pleft_q <= AMD_CNT_ZERO;
    end else if (take && !bad) begin
      ileft_q <= instr_bytes(instr_mode);
      pleft_q <= ptr_bytes(instr_mode);
    end else begin
      if (opnd_ack) begin
        ileft_q <= ileft_q - AMD_CNT_ONE;
      end
      if (ptr_ack) begin
        pleft_q <= pleft_q - AMD_CNT_ONE;
      end
    end
  end

  // Program counter walks past each operand byte taken.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pc_q <= '0;
    end else if (take && !bad) begin
      pc_q <= instr_pc;
    end else if (opnd_ack) begin
      pc_q <= pc_q + AMD_ADDR_STEP;
    end
  end

  // Bus address: instruction stream first, then page-zero pointer bytes.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addr_q <= '0;
    end else if (take && !bad) begin
      addr_q <= instr_pc;
    end else if (opnd_last) begin
      addr_q <= {AMD_PAGE0_HI, ptr_base};
    end else if (opnd_ack || ptr_ack) begin
      addr_q <= addr_q + AMD_ADDR_STEP;
    end
  end

  // Operand and pointer words shift left, so the first byte lands high.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      word_q <= '0;
      ptr_q  <= '0;
    end else if (take && !bad) begin
      word_q <= '0;
      ptr_q  <= '0;
    end else begin
      if (opnd_ack) begin
        word_q <= {word_q[7:0], mem_rdata};
      end
      if (ptr_ack) begin
        ptr_q <= {ptr_q[7:0], mem_rdata};
      end
    end
  end

  // Results are registered from the completed decode.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      valid_q  <= 1'b0;
      ea_q     <= '0;
      imm_q    <= '0;
      rel_q    <= '0;
      npc_q    <= '0;
      obytes_q <= AMD_CNT_ZERO;
    end else begin
      valid_q <= (st_q == ST_DONE);
      if (st_q == ST_DONE) begin
        ea_q     <= eif.ea;
        npc_q    <= pc_q;
        obytes_q <= nbytes_q;
        imm_q    <= (mode_q == AMD_IMM) ? word_q[7:0] : '0;
        unique case (mode_q)
          AMD_REL_D, AMD_BITREL_D, AMD_BITREL_I: rel_q <= word_q[7:0];
          AMD_REL_I:                             rel_q <= ptr_q[7:0];
          default:                               rel_q <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      err_q <= 1'b0;
    end else begin
      err_q <= take && bad;
    end
  end

  // Mask level changes only on inherent instructions.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_q <= AMD_MASK_BLOCK;
    end else if (take && instr_mode == AMD_INH) begin
      if (instr_mask_op == AMD_MOP_SET) begin
        mask_q <= AMD_MASK_BLOCK;
      end else if (instr_mask_op == AMD_MOP_CLR) begin
        mask_q <= AMD_MASK_OPEN;
      end
    end
  end

  assign ea_valid   = valid_q;
  assign ea_addr    = ea_q;
  assign imm_data   = imm_q;
  assign rel_offset = rel_q;
  assign next_pc    = npc_q;
  assign opnd_bytes = obytes_q;
  assign mode_error = err_q;
  assign int_mask   = mask_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence s_take(amd_mode_t m);
    take && !bad && instr_mode == m;
  endsequence

  sequence s_ptr_end;
    ptr_last;
  endsequence

  sequence s_finish;
    (st_q == ST_DONE) ##1 ea_valid;
  endsequence

  a_inh_no_fetch: assert property (
    s_take(AMD_INH) |-> ##1 (!mem_req && st_q == ST_DONE) ##1 (ea_valid && opnd_bytes == AMD_CNT_ZERO))
    else $error("inherent mode fetched operand bytes");

  a_imm_len: assert property (
    ea_valid && mode_q == AMD_IMM |-> opnd_bytes == AMD_CNT_ONE && imm_data == word_q[7:0])
    else $error("immediate mode length or value wrong");

  a_short_page: assert property (
    ea_valid && is_page0(mode_q) |-> ea_addr[15:8] == AMD_PAGE0_HI && opnd_bytes <= AMD_CNT_TWO)
    else $error("short mode address left page zero");

  a_direct_short: assert property (
    ea_valid && mode_q == AMD_DIR_S |-> ea_addr == {AMD_PAGE0_HI, word_q[7:0]} && opnd_bytes == AMD_CNT_ONE)
    else $error("direct short address wrong");

  a_long_word: assert property (
    ea_valid && mode_q == AMD_DIR_L |-> ea_addr == word_q && opnd_bytes == AMD_CNT_TWO)
    else $error("direct long address wrong");

  a_idx_short_sum: assert property (
    ea_valid && mode_q == AMD_IDX_S |-> ea_addr == 16'(idx_q) + 16'(word_q[7:0]))
    else $error("short indexed sum wrong or wrapped");

  a_idx_long_sum: assert property (
    ea_valid && mode_q == AMD_IDX_L |-> ea_addr == word_q + 16'(idx_q))
    else $error("long indexed sum wrong");

  // A word pointer stored at the top of page zero has its low byte at the first address above it.
  a_ptr_page_zero: assert property (
    st_q == ST_PTR |-> mem_req && (mem_addr[15:8] == AMD_PAGE0_HI ||
      (pleft_q == AMD_CNT_ONE && mem_addr == {AMD_PAGE0_HI + 8'h01, 8'h00})))
    else $error("pointer read outside page zero");

  a_ptr_finish: assert property (
    s_ptr_end |=> s_finish)
    else $error("pointer read did not end the decode");

  a_rmw_refused: assert property (
    take && bad |=> mode_error && st_q == ST_IDLE && !mem_req)
    else $error("long read-modify-write form not refused");

  a_mask_set: assert property (
    take && instr_mode == AMD_INH && instr_mask_op == AMD_MOP_SET |=> int_mask == AMD_MASK_BLOCK)
    else $error("mask not raised to level three");

  a_mask_clear: assert property (
    take && instr_mode == AMD_INH && instr_mask_op == AMD_MOP_CLR |=> int_mask == AMD_MASK_OPEN)
    else $error("mask not lowered to level zero");

endmodule

/* File: rtl/amd_pkg.sv */
package amd_pkg;

  typedef enum logic [4:0] {
    AMD_INH      = 5'h00,
    AMD_IMM      = 5'h01,
    AMD_DIR_S    = 5'h02,
    AMD_DIR_L    = 5'h03,
    AMD_IDX_0    = 5'h04,
    AMD_IDX_S    = 5'h05,
    AMD_IDX_L    = 5'h06,
    AMD_IND_S    = 5'h07,
    AMD_IND_L    = 5'h08,
    AMD_INDX_S   = 5'h09,
    AMD_INDX_L   = 5'h0A,
    AMD_REL_D    = 5'h0B,
    AMD_REL_I    = 5'h0C,
    AMD_BIT_D    = 5'h0D,
    AMD_BIT_I    = 5'h0E,
    AMD_BITREL_D = 5'h0F,
    AMD_BITREL_I = 5'h10
  } amd_mode_t;

  typedef enum logic [1:0] {
    AMD_MOP_NONE = 2'h0,
    AMD_MOP_SET  = 2'h1,
    AMD_MOP_CLR  = 2'h2
  } amd_mask_op_t;

  localparam logic [1:0] AMD_MASK_BLOCK = 2'h3;
  localparam logic [1:0] AMD_MASK_OPEN  = 2'h0;
  localparam logic [1:0] AMD_CNT_ZERO   = 2'h0;
  localparam logic [1:0] AMD_CNT_ONE    = 2'h1;
  localparam logic [1:0] AMD_CNT_TWO    = 2'h2;
  localparam logic [7:0] AMD_PAGE0_HI   = 8'h00;
  localparam logic [15:0] AMD_ADDR_STEP = 16'h0001;

  // Operand bytes that follow the opcode in the instruction stream.
  function automatic logic [1:0] instr_bytes(input amd_mode_t m);
    unique case (m)
      AMD_INH, AMD_IDX_0:                  instr_bytes = AMD_CNT_ZERO;
      AMD_DIR_L, AMD_IDX_L, AMD_BITREL_D,
      AMD_BITREL_I:                        instr_bytes = AMD_CNT_TWO;
      default:                             instr_bytes = AMD_CNT_ONE;
    endcase
  endfunction

  // Pointer bytes read from page zero.
  function automatic logic [1:0] ptr_bytes(input amd_mode_t m);
    unique case (m)
      AMD_IND_L, AMD_INDX_L:                         ptr_bytes = AMD_CNT_TWO;
      AMD_IND_S, AMD_INDX_S, AMD_REL_I, AMD_BIT_I,
      AMD_BITREL_I:                                  ptr_bytes = AMD_CNT_ONE;
      default:                                       ptr_bytes = AMD_CNT_ZERO;
    endcase
  endfunction

  // Modes whose operand address always lies in page zero.
  function automatic logic is_page0(input amd_mode_t m);
    is_page0 = m inside {AMD_DIR_S, AMD_IDX_0, AMD_IND_S, AMD_BIT_D,
                         AMD_BIT_I, AMD_BITREL_D, AMD_BITREL_I};
  endfunction

  // Long forms, refused for read-modify-write operations.
  function automatic logic is_long(input amd_mode_t m);
    is_long = m inside {AMD_DIR_L, AMD_IDX_L, AMD_IND_L, AMD_INDX_L};
  endfunction

endpackage

/* File: rtl/amd_ea_if.sv */
`timescale 1ns/1ps
interface amd_ea_if;
  import amd_pkg::*;
  amd_mode_t   mode;
  logic [7:0]  idx;
  logic [15:0] word;
  logic [15:0] ptr;
  logic [15:0] pc;
  logic [15:0] ea;
  modport calc (input mode, input idx, input word, input ptr, input pc, output ea);
  modport user (output mode, output idx, output word, output ptr, output pc, input ea);
endinterface

/* File: rtl/amd_ea_calc.sv */
`timescale 1ns/1ps
module amd_ea_calc (
  amd_ea_if.calc ea
);
  import amd_pkg::*;

  function automatic logic [15:0] zpage(input logic [7:0] lo);
    zpage = {AMD_PAGE0_HI, lo};
  endfunction

  // Index plus byte offset carries into the high byte, giving up to 1FE.
  function automatic logic [15:0] add_short(input logic [7:0] a, input logic [7:0] b);
    add_short = 16'(a) + 16'(b);
  endfunction

  function automatic logic [15:0] add_rel(input logic [15:0] pc, input logic [7:0] off);
    add_rel = pc + {{8{off[7]}}, off};
  endfunction

  always_comb begin
    unique case (ea.mode)
      AMD_DIR_S, AMD_BIT_D:   ea.ea = zpage(ea.word[7:0]);
      AMD_DIR_L:              ea.ea = ea.word;
      AMD_IDX_0:              ea.ea = zpage(ea.idx);
      AMD_IDX_S:              ea.ea = add_short(ea.idx, ea.word[7:0]);
      AMD_IDX_L:              ea.ea = ea.word + 16'(ea.idx);
      AMD_IND_S, AMD_BIT_I,
      AMD_BITREL_I:           ea.ea = zpage(ea.ptr[7:0]);
      AMD_IND_L:              ea.ea = ea.ptr;
      AMD_INDX_S:             ea.ea = add_short(ea.idx, ea.ptr[7:0]);
      AMD_INDX_L:             ea.ea = ea.ptr + 16'(ea.idx);
      AMD_REL_D:              ea.ea = add_rel(ea.pc, ea.word[7:0]);
      AMD_REL_I:              ea.ea = add_rel(ea.pc, ea.ptr[7:0]);
      AMD_BITREL_D:           ea.ea = zpage(ea.word[15:8]);
      default:                ea.ea = '0;
    endcase
  end

endmodule

/* File: test/amd_mem_model.sv */
`timescale 1ns/1ps
module amd_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  output logic             mem_ack,
  output logic [7:0]       mem_rdata
);
  logic [7:0] cyc_q;

  function automatic logic [7:0] byte_at(input logic [15:0] a);
    byte_at = a[7:0] ^ {a[12:8], a[15:13]} ^ 8'hA5;
  endfunction

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cyc_q <= 8'h00;
    end else begin
      cyc_q <= cyc_q + 8'h01;
    end
  end

  // A slow memory answers one cycle in four; the data lines carry a moving pattern while no answer stands.
  assign mem_ack   = mem_req && (!slow || cyc_q[1:0] == 2'h3);
  assign mem_rdata = mem_ack ? byte_at(mem_addr) : (cyc_q ^ 8'h5A);
endmodule

/* File: test/test_cpu_addressing_mode_decoder.sv */
`timescale 1ns/1ps
module test_cpu_addressing_mode_decoder;
  import amd_pkg::*;
  typedef struct packed {
    logic        err;
    logic [15:0] ea;
    logic [7:0]  imm;
    logic [7:0]  rel;
    logic [15:0] npc;
    logic [1:0]  nb;
    logic [1:0]  mask;
  } amd_tb_exp_t;

  logic         ref_clk = 1'b0;
  logic         rst = 1'b1;
  logic         slow = 1'b0;
  logic         instr_valid = 1'b0;
  logic         instr_ready;
  amd_mode_t    instr_mode = AMD_INH;
  amd_mask_op_t instr_mask_op = AMD_MOP_NONE;
  logic         instr_rmw = 1'b0;
  logic         instr_use_y = 1'b0;
  logic [15:0]  instr_pc = 16'h0000;
  logic [7:0]   idx_x = 8'h00;
  logic [7:0]   idx_y = 8'h00;
  logic         mem_req;
  logic [15:0]  mem_addr;
  logic [7:0]   mem_rdata;
  logic         mem_ack;
  logic         ea_valid;
  logic [15:0]  ea_addr;
  logic [7:0]   imm_data;
  logic [7:0]   rel_offset;
  logic [15:0]  next_pc;
  logic [1:0]   opnd_bytes;
  logic         mode_error;
  logic [1:0]   int_mask;
  int           fails = 0;
  int           samples_checked = 0;
  int           cyc = 0;
  integer       seed = 32'hdfa5;
  logic [1:0]   mask_e;
  amd_tb_exp_t  exp_q[$];

  amd_decoder DUT (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .instr_mode(instr_mode), .instr_mask_op(instr_mask_op), .instr_rmw(instr_rmw), .instr_use_y(instr_use_y),
    .instr_pc(instr_pc), .idx_x(idx_x), .idx_y(idx_y), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack), .ea_valid(ea_valid), .ea_addr(ea_addr), .imm_data(imm_data),
    .rel_offset(rel_offset), .next_pc(next_pc), .opnd_bytes(opnd_bytes), .mode_error(mode_error),
    .int_mask(int_mask));

  amd_mem_model mem (.ref_clk(ref_clk), .rst(rst), .slow(slow), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always #20 ref_clk = ~ref_clk;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  always @(posedge ref_clk) begin
    amd_tb_exp_t e;
    if (!rst && (ea_valid === 1'b1 || mode_error === 1'b1)) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("[ERR] result expected none seen one");
      end else begin
        e = exp_q.pop_front();
        chk("mode_error", {15'h0000, e.err}, {15'h0000, mode_error});
        chk("int_mask", {14'h0000, e.mask}, {14'h0000, int_mask});
        if (!e.err) begin
          chk("ea_addr", e.ea, ea_addr);
          chk("imm_data", {8'h00, e.imm}, {8'h00, imm_data});
          chk("rel_offset", {8'h00, e.rel}, {8'h00, rel_offset});
          chk("next_pc", e.npc, next_pc);
          chk("opnd_bytes", {14'h0000, e.nb}, {14'h0000, opnd_bytes});
        end
      end
    end
  end

  task automatic issue(input amd_mode_t m, input logic rmw, input amd_mask_op_t op);
    logic [15:0] p;
    logic [15:0] w;
    logic [15:0] q;
    logic [15:0] pw;
    logic [7:0]  ix;
    amd_tb_exp_t e;
    int          n;
    p  = $random(seed);
    e  = '0;
    w  = {mem.byte_at(p), mem.byte_at(p + 16'h0001)};
    q  = {8'h00, mem.byte_at(p)};
    pw = {mem.byte_at(q), mem.byte_at(q + 16'h0001)};
    @(negedge ref_clk);
    idx_x       = $random(seed);
    idx_y       = $random(seed);
    instr_use_y = $random(seed);
    ix          = instr_use_y ? idx_y : idx_x;
    e.err = rmw && (m inside {AMD_DIR_L, AMD_IDX_L, AMD_IND_L, AMD_INDX_L});
    e.nb  = (m inside {AMD_INH, AMD_IDX_0}) ? 2'h0 : (m inside {AMD_DIR_L, AMD_IDX_L, AMD_BITREL_D,
      AMD_BITREL_I}) ? 2'h2 : 2'h1;
    e.npc = p + {14'h0000, e.nb};
    case (m)
      AMD_INH: begin
        if (op == AMD_MOP_SET) mask_e = AMD_MASK_BLOCK;
        if (op == AMD_MOP_CLR) mask_e = AMD_MASK_OPEN;
      end
      AMD_IMM: e.imm = q[7:0];
      AMD_DIR_S, AMD_BIT_D: e.ea = q;
      AMD_DIR_L: e.ea = w;
      AMD_IDX_0: e.ea = {8'h00, ix};
      AMD_IDX_S: e.ea = q + {8'h00, ix};
      AMD_IDX_L: e.ea = w + {8'h00, ix};
      AMD_IND_S, AMD_BIT_I: e.ea = {8'h00, pw[15:8]};
      AMD_IND_L: e.ea = pw;
      AMD_INDX_S: e.ea = {8'h00, pw[15:8]} + {8'h00, ix};
      AMD_INDX_L: e.ea = pw + {8'h00, ix};
      AMD_REL_D: e.rel = q[7:0];
      AMD_REL_I: e.rel = pw[15:8];
      AMD_BITREL_D: e.ea = q;
      default: e.ea = {8'h00, pw[15:8]};
    endcase
    if (m inside {AMD_BITREL_D, AMD_BITREL_I}) e.rel = w[7:0];
    if (m inside {AMD_REL_D, AMD_REL_I}) e.ea = e.npc + {{8{e.rel[7]}}, e.rel};
    e.mask = mask_e;
    n = 0;
    while (instr_ready !== 1'b1 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    instr_mode    = m;
    instr_rmw     = rmw;
    instr_mask_op = op;
    instr_pc      = p;
    instr_valid   = 1'b1;
    exp_q.push_back(e);
    @(negedge ref_clk);
    instr_valid = 1'b0;
  endtask

  task automatic drain_and_reset();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    chk("pending", 16'h0000, exp_q.size());
    rst = 1'b1;
    repeat (12) @(negedge ref_clk);
    rst    = 1'b0;
    mask_e = AMD_MASK_BLOCK;
    chk("reset int_mask", {14'h0000, AMD_MASK_BLOCK}, {14'h0000, int_mask});
    chk("reset mem_req", 16'h0000, {15'h0000, mem_req});
  endtask

  initial begin
    drain_and_reset();
    for (int r = 0; r < 6; r++) begin
      slow = r[0];
      for (int m = 0; m < 17; m++) begin
        issue(amd_mode_t'(m), r >= 4, amd_mask_op_t'(r % 3));
      end
    end
    for (int k = 0; k < 40; k++) begin
      slow = $random(seed);
      issue(amd_mode_t'(($random(seed) & 32'h7FFF) % 17), $random(seed), amd_mask_op_t'(k % 3));
    end
    issue(AMD_INH, 1'b0, AMD_MOP_CLR);
    drain_and_reset();
    issue(AMD_IND_L, 1'b0, AMD_MOP_NONE);
    drain_and_reset();
    summarize();
  end
endmodule
